// *** hdl/msd_pkg.sv ***
// shared constants and types for the memory space decoder
package msd_pkg;

  // program flash ends and the lock byte
  localparam logic [15:0] FLASH_TOP_LARGE = 16'h3bff;
  localparam logic [15:0] FLASH_TOP_SMALL = 16'h1fff;

  // data memory sizes and boundaries
  localparam int          IRAM_BYTES = 256;
  localparam int          ONCHIP_EXTERNAL_RAM_BYTES = 512;
  localparam logic [6:0]  ONCHIP_EXTERNAL_RAM_HIGH_ZERO = 7'h00;
  localparam logic [7:0]  BIT_BASE   = 8'h20;
  localparam logic [15:0] MUL_LIMIT  = 16'h00ff;

  // status word bit positions
  localparam int PSW_F1_BIT  = 1;
  localparam int PSW_OV_BIT  = 2;
  localparam int PSW_RS0_BIT = 3;
  localparam int PSW_RS1_BIT = 4;

  // control register bit positions
  localparam int CTRL_FLWR_BIT  = 0;
  localparam int CTRL_SMALL_BIT = 1;
  localparam int PAGE_BIT       = 0;

  // register port offsets
  localparam logic [2:0] REG_PSW  = 3'h0;
  localparam logic [2:0] REG_SP   = 3'h1;
  localparam logic [2:0] REG_DPL  = 3'h2;
  localparam logic [2:0] REG_DPH  = 3'h3;
  localparam logic [2:0] REG_PAGE = 3'h4;
  localparam logic [2:0] REG_CTRL = 3'h5;

  // reset values
  localparam logic [7:0]  PSW_RESET  = 8'h00;
  localparam logic [7:0]  SP_RESET   = 8'h07;
  localparam logic [15:0] WIDE_DATA_POINTER_RESET = 16'h0000;
  localparam logic        PAGE_RESET = 1'b0;
  localparam logic [1:0]  CTRL_RESET = 2'h0;

  typedef enum logic [3:0] {
    KIND_CODE_RD  = 4'h0,
    KIND_XDP_RD   = 4'h1,
    KIND_XDP_WR   = 4'h2,
    KIND_XPG_RD   = 4'h3,
    KIND_XPG_WR   = 4'h4,
    KIND_DIR_RD   = 4'h5,
    KIND_DIR_WR   = 4'h6,
    KIND_IND_RD   = 4'h7,
    KIND_IND_WR   = 4'h8,
    KIND_BIT_RD   = 4'h9,
    KIND_BIT_WR   = 4'ha,
    KIND_PUSH     = 4'hb,
    KIND_POP      = 4'hc,
    KIND_REG_RD   = 4'hd,
    KIND_REG_WR   = 4'he
  } msd_kind_e;

  typedef enum logic [2:0] {
    ALU_NONE = 3'h0,
    ALU_ADD  = 3'h1,
    ALU_ADDC = 3'h2,
    ALU_SUBB = 3'h3,
    ALU_MUL  = 3'h4,
    ALU_DIV  = 3'h5
  } msd_alu_e;

  typedef struct packed {
    msd_kind_e   kind;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } msd_req_s;

  typedef struct packed {
    msd_alu_e   op;
    logic [7:0] a;
    logic [7:0] b;
    logic       cy;
  } msd_alu_s;

  typedef struct packed {
    logic        valid;
    logic [7:0]  rdata;
    logic        sfr;
    logic        flash_rd;
    logic        flash_wr;
    logic        reserved;
    logic        lock;
    logic [15:0] addr;
  } msd_rsp_s;

endpackage

// *** hdl/msd_decoder.sv ***
// memory space decoder: internal ram, banks, bits, stack, onchip_external_ram, flags
// What this block does
// - overflow set on signed add/sub overflow, product above 255, zero divisor
// - add, addc, subb, mul, div clear overflow when no overflow occurs
// - code and data spaces overlap; instruction kind picks the space
// - flash is one block from zero to 0x3bff or 0x1fff by variant
// - last flash byte is the lock byte; addresses above it are reserved
// - code reads always from flash; xmove writes hit flash only if enabled
// - xmove reads and writes go to on-chip onchip_external_ram by default
// - 768 ram bytes: 256 internal, the rest in external space
// - lower 128 internal bytes reachable directly and indirectly
// - above 0x7f indirect hits upper ram, direct hits special registers
// - 0x00 to 0x1f form four banks of eight working registers
// - one bank active, chosen by status word bits 3 and 4
// - indirect pointer comes from register 0 or 1 of active bank
// - bytes 0x20-0x2f are 128 bits, address eight times offset plus bit
// - bit or byte access chosen by instruction kind, not address
// - stack pointer holds last used slot; push writes pointer plus one
// - reset loads stack pointer 0x07 so first push lands at 0x08
// - stack may sit anywhere in the 256 internal bytes
// - 512 onchip_external_ram bytes reached by wide pointer or index plus page
// - one-bit page register supplies address bit 8 for 8-bit xmoves
// - bank select 00,01,10,11 map registers to 0x00,0x08,0x10,0x18
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module msd_decoder (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic             req_valid_i,
  input  wire msd_pkg::msd_req_s req_i,
  input  wire logic             alu_valid_i,
  input  wire msd_pkg::msd_alu_s alu_i,
  input  wire logic [2:0]       reg_addr_i,
  input  wire logic [7:0]       reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic [7:0]            reg_rdata_o,
  output msd_pkg::msd_rsp_s     rsp_o
);

  function automatic logic [7:0] bank_addr(input logic [1:0] rs,
                                           input logic [2:0] r);
    return {3'b000, rs, r};
  endfunction

  function automatic logic ov_calc(input msd_pkg::msd_alu_s op);
    logic [7:0]  s;
    logic [15:0] p;
    s = 8'h00;
    p = {8'h00, op.a} * {8'h00, op.b};
    ov_calc = 1'b0;
    unique case (op.op)
      msd_pkg::ALU_ADD, msd_pkg::ALU_ADDC:
      begin
        s = op.a + op.b + {7'h00, op.cy & (op.op == msd_pkg::ALU_ADDC)};
        ov_calc = (op.a[7] == op.b[7]) && (s[7] != op.a[7]);
      end
      msd_pkg::ALU_SUBB:
      begin
        s = op.a - op.b - {7'h00, op.cy};
        ov_calc = (op.a[7] != op.b[7]) && (s[7] != op.a[7]);
      end
      msd_pkg::ALU_MUL: ov_calc = p > msd_pkg::MUL_LIMIT;
      msd_pkg::ALU_DIV: ov_calc = op.b == 8'h00;
      default: ov_calc = 1'b0;
    endcase
  endfunction

  logic [7:0]  iram_q [msd_pkg::IRAM_BYTES];
  logic [7:0]  onchip_external_ram_q [msd_pkg::ONCHIP_EXTERNAL_RAM_BYTES];
  logic [7:0]  psw_q;
  logic [7:0]  sp_q;
  logic [7:0]  sp_d;
  logic [15:0] wide_data_pointer_q;
  logic        page_q;
  logic [1:0]  ctrl_q;
  logic [7:0]  reg_rdata_q;
  msd_pkg::msd_rsp_s rsp_q;
  msd_pkg::msd_rsp_s rsp_d;

  logic        sp_we;
  logic        iram_we;
  logic [7:0]  iram_wa;
  logic [7:0]  iram_wd;
  logic        onchip_external_ram_we;
  logic [8:0]  onchip_external_ram_wa;
  logic [1:0]  rs;
  logic [7:0]  ri_ptr;
  logic [7:0]  bit_byte;
  logic [15:0] xaddr;
  logic [15:0] flash_top;
  logic        xaddr_ok;

  assign rs = {psw_q[msd_pkg::PSW_RS1_BIT], psw_q[msd_pkg::PSW_RS0_BIT]};
  assign ri_ptr = iram_q[bank_addr(rs, {2'b00, req_i.addr[0]})];
  assign bit_byte = msd_pkg::BIT_BASE + {4'h0, req_i.addr[6:3]};
  assign flash_top = ctrl_q[msd_pkg::CTRL_SMALL_BIT] ?
                     msd_pkg::FLASH_TOP_SMALL : msd_pkg::FLASH_TOP_LARGE;
  assign xaddr = (req_i.kind == msd_pkg::KIND_XPG_RD ||
                  req_i.kind == msd_pkg::KIND_XPG_WR) ?
                 {7'h00, page_q, ri_ptr} : wide_data_pointer_q;
  assign xaddr_ok = xaddr[15:9] == msd_pkg::ONCHIP_EXTERNAL_RAM_HIGH_ZERO;

  // request decode: the kind of access picks the space
  always_comb
  begin
    rsp_d = '0;
    rsp_d.valid = req_valid_i;
    sp_d = sp_q;
    sp_we = 1'b0;
    iram_we = 1'b0;
    iram_wa = req_i.addr[7:0];
    iram_wd = req_i.wdata;
    onchip_external_ram_we = 1'b0;
    onchip_external_ram_wa = xaddr[8:0];
    if (req_valid_i)
    begin
      unique case (req_i.kind)
        msd_pkg::KIND_CODE_RD:
        begin
          rsp_d.flash_rd = 1'b1;
          rsp_d.addr = req_i.addr;
          rsp_d.reserved = req_i.addr > flash_top;
          rsp_d.lock = req_i.addr == flash_top;
        end
        msd_pkg::KIND_XDP_RD, msd_pkg::KIND_XPG_RD:
        begin
          rsp_d.addr = xaddr;
          rsp_d.reserved = !xaddr_ok;
          rsp_d.rdata = xaddr_ok ? onchip_external_ram_q[xaddr[8:0]] : 8'h00;
        end
        msd_pkg::KIND_XDP_WR, msd_pkg::KIND_XPG_WR:
        begin
          rsp_d.addr = xaddr;
          if (ctrl_q[msd_pkg::CTRL_FLWR_BIT])
          begin
            rsp_d.flash_wr = 1'b1;
            rsp_d.reserved = xaddr > flash_top;
            rsp_d.lock = xaddr == flash_top;
          end
          else
          begin
            rsp_d.reserved = !xaddr_ok;
            onchip_external_ram_we = xaddr_ok;
          end
        end
        msd_pkg::KIND_DIR_RD:
        begin
          rsp_d.addr = {8'h00, req_i.addr[7:0]};
          rsp_d.sfr = req_i.addr[7];
          rsp_d.rdata = req_i.addr[7] ? 8'h00 : iram_q[req_i.addr[7:0]];
        end
        msd_pkg::KIND_DIR_WR:
        begin
          rsp_d.addr = {8'h00, req_i.addr[7:0]};
          rsp_d.sfr = req_i.addr[7];
          iram_we = !req_i.addr[7];
        end
        msd_pkg::KIND_IND_RD:
        begin
          rsp_d.addr = {8'h00, ri_ptr};
          rsp_d.rdata = iram_q[ri_ptr];
        end
        msd_pkg::KIND_IND_WR:
        begin
          rsp_d.addr = {8'h00, ri_ptr};
          iram_we = 1'b1;
          iram_wa = ri_ptr;
        end
        msd_pkg::KIND_BIT_RD:
        begin
          rsp_d.sfr = req_i.addr[7];
          rsp_d.addr = {8'h00, bit_byte};
          rsp_d.rdata = req_i.addr[7] ? 8'h00 :
                        {7'h00, iram_q[bit_byte][req_i.addr[2:0]]};
        end
        msd_pkg::KIND_BIT_WR:
        begin
          rsp_d.sfr = req_i.addr[7];
          rsp_d.addr = {8'h00, bit_byte};
          iram_we = !req_i.addr[7];
          iram_wa = bit_byte;
          iram_wd = iram_q[bit_byte];
          iram_wd[req_i.addr[2:0]] = req_i.wdata[0];
        end
        msd_pkg::KIND_PUSH:
        begin
          sp_d = sp_q + 8'h01;
          sp_we = 1'b1;
          iram_we = 1'b1;
          iram_wa = sp_d;
          rsp_d.addr = {8'h00, sp_d};
        end
        msd_pkg::KIND_POP:
        begin
          rsp_d.rdata = iram_q[sp_q];
          rsp_d.addr = {8'h00, sp_q};
          sp_d = sp_q - 8'h01;
          sp_we = 1'b1;
        end
        msd_pkg::KIND_REG_RD:
        begin
          iram_wa = bank_addr(rs, req_i.addr[2:0]);
          rsp_d.addr = {8'h00, iram_wa};
          rsp_d.rdata = iram_q[iram_wa];
        end
        msd_pkg::KIND_REG_WR:
        begin
          iram_wa = bank_addr(rs, req_i.addr[2:0]);
          rsp_d.addr = {8'h00, iram_wa};
          iram_we = 1'b1;
        end
        default: rsp_d.reserved = 1'b1;
      endcase
    end
  end

  // internal and external ram storage
  always_ff @(posedge clk_sys_i)
  begin
    if (iram_we)
      iram_q[iram_wa] <= iram_wd;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (onchip_external_ram_we)
      onchip_external_ram_q[onchip_external_ram_wa] <= req_i.wdata;
  end

  // stack pointer: core update wins over a register write
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      sp_q <= msd_pkg::SP_RESET;
    else if (sp_we)
      sp_q <= sp_d;
    else if (reg_wr_i && reg_addr_i == msd_pkg::REG_SP)
      sp_q <= reg_wdata_i;
  end

  // status word: arithmetic result wins over a register write
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      psw_q <= msd_pkg::PSW_RESET;
    else
    begin
      if (reg_wr_i && reg_addr_i == msd_pkg::REG_PSW)
        psw_q <= reg_wdata_i;
      if (alu_valid_i && alu_i.op != msd_pkg::ALU_NONE)
        psw_q[msd_pkg::PSW_OV_BIT] <= ov_calc(alu_i);
    end
  end

  // pointer, page and control registers
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      wide_data_pointer_q <= msd_pkg::WIDE_DATA_POINTER_RESET;
      page_q <= msd_pkg::PAGE_RESET;
      ctrl_q <= msd_pkg::CTRL_RESET;
    end
    else if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        msd_pkg::REG_DPL:  wide_data_pointer_q[7:0] <= reg_wdata_i;
        msd_pkg::REG_DPH:  wide_data_pointer_q[15:8] <= reg_wdata_i;
        msd_pkg::REG_PAGE: page_q <= reg_wdata_i[msd_pkg::PAGE_BIT];
        msd_pkg::REG_CTRL: ctrl_q <= reg_wdata_i[1:0];
        default: ;
      endcase
    end
  end

  // register read data one cycle after the strobe
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || !reg_rd_i)
      reg_rdata_q <= 8'h00;
    else
    begin
      unique case (reg_addr_i)
        msd_pkg::REG_PSW:  reg_rdata_q <= psw_q;
        msd_pkg::REG_SP:   reg_rdata_q <= sp_q;
        msd_pkg::REG_DPL:  reg_rdata_q <= wide_data_pointer_q[7:0];
        msd_pkg::REG_DPH:  reg_rdata_q <= wide_data_pointer_q[15:8];
        msd_pkg::REG_PAGE: reg_rdata_q <= {7'h00, page_q};
        msd_pkg::REG_CTRL: reg_rdata_q <= {6'h00, ctrl_q};
        default:           reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // core answer one cycle after the request
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      rsp_q <= '0;
    else
      rsp_q <= rsp_d;
  end

  assign reg_rdata_o = reg_rdata_q;
  assign rsp_o = rsp_q;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  a_sp_reset_value: assert property (disable iff (1'b0)
    rst_i |=> sp_q == msd_pkg::SP_RESET)
    else $error("stack pointer not reloaded by reset");

  a_push_slot_incr: assert property (
    req_valid_i && req_i.kind == msd_pkg::KIND_PUSH
    |=> sp_q == $past(sp_q) + 8'h01 && rsp_q.addr[7:0] == sp_q)
    else $error("push did not land one above the old pointer");

  a_pop_wraps_down: assert property (
    req_valid_i && req_i.kind == msd_pkg::KIND_POP && sp_q == 8'h00
    |=> sp_q == 8'hff)
    else $error("pop from zero did not wrap");

  a_mul_sets_ov: assert property (
    alu_valid_i && alu_i.op == msd_pkg::ALU_MUL &&
    ({8'h00, alu_i.a} * {8'h00, alu_i.b}) > msd_pkg::MUL_LIMIT
    |=> psw_q[msd_pkg::PSW_OV_BIT])
    else $error("large product left overflow clear");

  a_div_ov_clear: assert property (
    alu_valid_i && alu_i.op == msd_pkg::ALU_DIV && alu_i.b != 8'h00
    |=> !psw_q[msd_pkg::PSW_OV_BIT])
    else $error("nonzero divide left overflow set");

  a_code_from_flash: assert property (
    req_valid_i && req_i.kind == msd_pkg::KIND_CODE_RD
    |=> rsp_q.flash_rd && !rsp_q.flash_wr && !rsp_q.sfr)
    else $error("code read not served from flash");

  a_xmove_default_ram: assert property (
    req_valid_i && req_i.kind == msd_pkg::KIND_XDP_WR &&
    !ctrl_q[msd_pkg::CTRL_FLWR_BIT] |=> !rsp_q.flash_wr)
    else $error("xmove write reached flash while disabled");

  a_direct_high_sfr: assert property (
    req_valid_i && req_i.kind == msd_pkg::KIND_DIR_RD && req_i.addr[7]
    |=> rsp_q.sfr && rsp_q.valid && rsp_q.rdata == 8'h00)
    else $error("direct high access missed special registers");

  a_indirect_high_ram: assert property (
    req_valid_i && req_i.kind == msd_pkg::KIND_IND_RD && ri_ptr[7]
    |=> !rsp_q.sfr && rsp_q.addr == {8'h00, $past(ri_ptr)})
    else $error("indirect high access left upper ram");

  a_flash_reserved: assert property (
    req_valid_i && req_i.kind == msd_pkg::KIND_CODE_RD &&
    req_i.addr > flash_top |=> rsp_q.reserved && !rsp_q.lock)
    else $error("address above lock byte not reserved");

  a_page_high_byte: assert property (
    req_valid_i && req_i.kind == msd_pkg::KIND_XPG_RD
    |=> rsp_q.addr[15:8] == {7'h00, $past(page_q)})
    else $error("page register not used as high byte");

  c_push_then_pop: cover property (
    req_valid_i && req_i.kind == msd_pkg::KIND_PUSH ##1
    req_valid_i && req_i.kind == msd_pkg::KIND_POP);
  c_bit_write: cover property (
    req_valid_i && req_i.kind == msd_pkg::KIND_BIT_WR && !req_i.addr[7]);
  c_flash_write: cover property (rsp_q.flash_wr);
  c_page_one: cover property (rsp_q.valid && rsp_q.addr[15:8] == 8'h01);

endmodule

// *** testbench/msd_core_model.sv ***
// core load and store unit model driving the decoder requests
`timescale 1ns/1ps
module msd_core_model (
  input  wire logic         clk_sys_i,
  output logic              req_valid_o,
  output msd_pkg::msd_req_s req_o,
  output logic              alu_valid_o,
  output msd_pkg::msd_alu_s alu_o
);
  int gap = 0;

  initial
  begin
    req_valid_o = 1'b0;
    req_o       = '0;
    alu_valid_o = 1'b0;
    alu_o       = '0;
  end

  // one request taken at the next edge; released fields show inverted data
  task automatic issue(input logic [3:0] k, input logic [15:0] a,
                       input logic [7:0] d);
    repeat (gap) @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    req_valid_o <= 1'b1;
    req_o       <= {msd_pkg::msd_kind_e'(k), a, d};
    @(posedge clk_sys_i);
    req_valid_o <= 1'b0;
    req_o       <= {msd_pkg::msd_kind_e'(k), ~a, ~d};
  endtask

  // one arithmetic result event
  task automatic alu(input logic [2:0] o, input logic [7:0] x,
                     input logic [7:0] y, input logic c);
    @(posedge clk_sys_i);
    alu_valid_o <= 1'b1;
    alu_o       <= {msd_pkg::msd_alu_e'(o), x, y, c};
    @(posedge clk_sys_i);
    alu_valid_o <= 1'b0;
    alu_o       <= {msd_pkg::ALU_NONE, ~x, ~y, ~c};
  endtask
endmodule

// *** testbench/mcu_memory_space_decoder_tb_top.sv ***
// self-checking bench for the memory space decoder
`timescale 1ns/1ps
module mcu_memory_space_decoder_tb_top;
  typedef struct packed {
    logic [3:0]  k;
    logic [15:0] a;
    logic [7:0]  d;
    logic [7:0]  rd;
    logic [15:0] ea;
    logic [5:0]  fl;
  } msd_row_s;

  logic              clk_sys_i;
  logic              rst_i;
  logic              req_valid_i;
  msd_pkg::msd_req_s req_i;
  logic              alu_valid_i;
  msd_pkg::msd_alu_s alu_i;
  logic [2:0]        reg_addr_i;
  logic [7:0]        reg_wdata_i;
  logic              reg_wr_i;
  logic              reg_rd_i;
  logic [7:0]        reg_rdata_o;
  msd_pkg::msd_rsp_s rsp_o;
  int                failures;
  int                total_checks;
  logic [7:0]        v;
  msd_row_s          rows [0:23];
  logic [20:0]       alus [0:8];

  msd_decoder uut (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .req_valid_i (req_valid_i),
    .req_i       (req_i),
    .alu_valid_i (alu_valid_i),
    .alu_i       (alu_i),
    .reg_addr_i  (reg_addr_i),
    .reg_wdata_i (reg_wdata_i),
    .reg_wr_i    (reg_wr_i),
    .reg_rd_i    (reg_rd_i),
    .reg_rdata_o (reg_rdata_o),
    .rsp_o       (rsp_o)
  );

  msd_core_model core (
    .clk_sys_i   (clk_sys_i),
    .req_valid_o (req_valid_i),
    .req_o       (req_i),
    .alu_valid_o (alu_valid_i),
    .alu_o       (alu_i)
  );

  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string n, input logic [15:0] s,
                       input logic [15:0] e);
    total_checks++;
    if (s !== e)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  // fl: check rdata, flash_wr, sfr, flash_rd, reserved, lock
  task automatic xfer(input logic [3:0] k, input logic [15:0] a,
                      input logic [7:0] d, input logic [7:0] erd,
                      input logic [15:0] ea, input logic [5:0] fl);
    core.issue(k, a, d);
    #1;
    check("valid", rsp_o.valid, 1'b1);
    check("addr", rsp_o.addr, ea);
    check("flags", {rsp_o.flash_wr, rsp_o.sfr, rsp_o.flash_rd,
                    rsp_o.reserved, rsp_o.lock}, fl[4:0]);
    if (fl[5])
      check("rdata", rsp_o.rdata, erd);
  endtask

  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    failures++;
    results();
  end

  initial
  begin
    rows = '{
      '{4'h6, 16'h0030, 8'ha5, 8'h00, 16'h0030, 6'h00},
      '{4'h5, 16'h0030, 8'h00, 8'ha5, 16'h0030, 6'h20},
      '{4'he, 16'h0000, 8'h30, 8'h00, 16'h0000, 6'h00},
      '{4'h7, 16'h0000, 8'h00, 8'ha5, 16'h0030, 6'h20},
      '{4'h6, 16'h0090, 8'h11, 8'h00, 16'h0090, 6'h08},
      '{4'he, 16'h0001, 8'h90, 8'h00, 16'h0001, 6'h00},
      '{4'h8, 16'h0001, 8'h3c, 8'h00, 16'h0090, 6'h00},
      '{4'h7, 16'h0001, 8'h00, 8'h3c, 16'h0090, 6'h20},
      '{4'h5, 16'h0090, 8'h00, 8'h00, 16'h0090, 6'h28},
      '{4'h6, 16'h0022, 8'h08, 8'h00, 16'h0022, 6'h00},
      '{4'h9, 16'h0013, 8'h00, 8'h01, 16'h0022, 6'h20},
      '{4'h9, 16'h0012, 8'h00, 8'h00, 16'h0022, 6'h20},
      '{4'h6, 16'h002f, 8'h00, 8'h00, 16'h002f, 6'h00},
      '{4'ha, 16'h007f, 8'h01, 8'h00, 16'h002f, 6'h00},
      '{4'h5, 16'h002f, 8'h00, 8'h80, 16'h002f, 6'h20},
      '{4'hb, 16'h0000, 8'h55, 8'h00, 16'h0008, 6'h00},
      '{4'hc, 16'h0000, 8'h00, 8'h55, 16'h0008, 6'h20},
      '{4'h2, 16'h0000, 8'h77, 8'h00, 16'h0000, 6'h00},
      '{4'h1, 16'h0000, 8'h00, 8'h77, 16'h0000, 6'h20},
      '{4'h4, 16'h0000, 8'h66, 8'h00, 16'h0030, 6'h00},
      '{4'h3, 16'h0000, 8'h00, 8'h66, 16'h0030, 6'h20},
      '{4'h0, 16'h0030, 8'h00, 8'h00, 16'h0030, 6'h04},
      '{4'h0, 16'h3bff, 8'h00, 8'h00, 16'h3bff, 6'h05},
      '{4'h0, 16'h3c00, 8'h00, 8'h00, 16'h3c00, 6'h06}};
    // op, a, b, carry in, expected overflow
    alus = '{{3'h1, 8'h7f, 8'h01, 2'b01}, {3'h1, 8'h01, 8'h01, 2'b00},
             {3'h2, 8'h7f, 8'h00, 2'b11}, {3'h3, 8'h80, 8'h01, 2'b01},
             {3'h3, 8'h05, 8'h01, 2'b00}, {3'h4, 8'h10, 8'h10, 2'b01},
             {3'h4, 8'h0f, 8'h11, 2'b00}, {3'h5, 8'h08, 8'h00, 2'b01},
             {3'h5, 8'h08, 8'h02, 2'b00}};
    failures     = 0;
    total_checks = 0;
    rst_i        = 1'b1;
    reg_addr_i   = 3'h0;
    reg_wdata_i  = 8'h00;
    reg_wr_i     = 1'b0;
    reg_rd_i     = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      bus_rd(3'(i), v);
      check("reg reset", v, (i == 1) ? 8'h07 : 8'h00);
    end
    foreach (rows[i])
      xfer(rows[i].k, rows[i].a, rows[i].d, rows[i].rd, rows[i].ea,
           rows[i].fl);
    core.gap = 2;
    for (int b = 0; b < 4; b++)
    begin
      bus_wr(msd_pkg::REG_PSW, 8'(b << 3));
      xfer(4'he, 16'h0003, 8'hc0 + 8'(b), 8'h00, 16'(8 * b + 3),
           6'h00);
      xfer(4'he, 16'h0000, 8'h40 + 8'(b), 8'h00, 16'(8 * b), 6'h00);
      xfer(4'h8, 16'h0000, 8'(b), 8'h00, 16'h0040 + 16'(b), 6'h00);
      xfer(4'h5, 16'(8 * b + 3), 8'h00, 8'hc0 + 8'(b), 16'(8 * b + 3),
           6'h20);
      xfer(4'hd, 16'h0003, 8'h00, 8'hc0 + 8'(b), 16'(8 * b + 3),
           6'h20);
    end
    core.gap = 0;
    bus_wr(msd_pkg::REG_PSW, 8'h00);
    bus_wr(msd_pkg::REG_PAGE, 8'hff);
    bus_rd(msd_pkg::REG_PAGE, v);
    check("page", v, 8'h01);
    xfer(4'h4, 16'h0001, 8'he1, 8'h00, 16'h0190, 6'h00);
    bus_wr(msd_pkg::REG_DPH, 8'h01);
    bus_wr(msd_pkg::REG_DPL, 8'h90);
    xfer(4'h1, 16'h0000, 8'h00, 8'he1, 16'h0190, 6'h20);
    bus_wr(msd_pkg::REG_DPH, 8'h02);
    bus_wr(msd_pkg::REG_DPL, 8'h00);
    xfer(4'h2, 16'h0000, 8'h99, 8'h00, 16'h0200, 6'h02);
    bus_wr(msd_pkg::REG_DPH, 8'h00);
    bus_wr(msd_pkg::REG_DPL, 8'h10);
    bus_wr(msd_pkg::REG_CTRL, 8'h01);
    xfer(4'h2, 16'h0000, 8'h12, 8'h00, 16'h0010, 6'h10);
    bus_wr(msd_pkg::REG_CTRL, 8'h03);
    xfer(4'h0, 16'h1fff, 8'h00, 8'h00, 16'h1fff, 6'h05);
    xfer(4'h0, 16'h2000, 8'h00, 8'h00, 16'h2000, 6'h06);
    bus_wr(msd_pkg::REG_SP, 8'hff);
    xfer(4'hb, 16'h0000, 8'h3e, 8'h00, 16'h0000, 6'h00);
    bus_rd(msd_pkg::REG_SP, v);
    check("sp", v, 8'h00);
    xfer(4'hc, 16'h0000, 8'h00, 8'h3e, 16'h0000, 6'h20);
    bus_rd(msd_pkg::REG_SP, v);
    check("sp", v, 8'hff);
    foreach (alus[i])
    begin
      core.alu(alus[i][20:18], alus[i][17:10], alus[i][9:2], alus[i][1]);
      bus_rd(msd_pkg::REG_PSW, v);
      check("overflow", v[2], alus[i][0]);
    end
    xfer(4'hf, 16'h0000, 8'h00, 8'h00, 16'h0000, 6'h02);
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    bus_rd(msd_pkg::REG_SP, v);
    check("sp", v, 8'h07);
    results();
  end
endmodule
